// [adcrw_pkg.sv]
/*
  Constants, field layout and state types for the acquisition control register.
  Assumes a single 100 MHz clock domain.
*/
package adcrw_pkg;
  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam int CTRL_W = 6;
  localparam int FMT_POS = 0;
  localparam int STBY_POS = 1;
  localparam int CONV_POS = 2;
  localparam int CHAN_LSB = 3;
  localparam int CHAN_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

  // ----------------------------------------------------------------
  // serial frame and timing
  // ----------------------------------------------------------------
  localparam int BCNT_W = 3;
  localparam logic [BCNT_W-1:0] SER_BITS = 3'h6;
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_NS = 600;
  localparam int SETTLE_RAW = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int CNT_W = 12;

  // ----------------------------------------------------------------
  // synchroniser lane positions
  // ----------------------------------------------------------------
  localparam int SY_W = 12;
  localparam int SY_DB = 0;
  localparam int SY_MODE = 6;
  localparam int SY_CS = 7;
  localparam int SY_WR = 8;
  localparam int SY_SCLK = 9;
  localparam int SY_TFS = 10;
  localparam int SY_DIN = 11;
  localparam logic [SY_W-1:0] SY_RST = 12'hfc0;

  typedef enum logic [0:0] {
    ADCRW_IDLE = 1'b0,
    ADCRW_SETTLE = 1'b1
  } adcrw_conv_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] shift;
    logic [BCNT_W-1:0] bitcnt;
    logic wr_q;
    logic sclk_q;
    logic tfs_q;
    adcrw_conv_t conv;
    logic [CNT_W-1:0] cnt;
    logic conv_start;
  } adcrw_state_t;

  localparam adcrw_state_t ST_RST = '{
    ctrl: CTRL_RST, shift: 6'h00, bitcnt: SER_BITS, wr_q: 1'b1, sclk_q: 1'b1,
    tfs_q: 1'b1, conv: ADCRW_IDLE, cnt: 12'h000, conv_start: 1'b0};
endpackage : adcrw_pkg

// [adcrw_sync.sv]
/*
  Two-flop synchroniser for a bundle of asynchronous pins.
  Assumes each lane is an independent level; no bus coherence is given.
*/
`timescale 1ns/1ps
module adcrw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } adcrw_sy_t;

  adcrw_sy_t s_r;
  adcrw_sy_t s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt.meta = d;
    s_nxt.stab = s_r.meta;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '{meta: RST_VAL, stab: RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stab;
endmodule : adcrw_sync

// [adcrw_ctrl.sv]
/*
  Acquisition control register with parallel and serial write ports and
  the software conversion settle timer.
  Assumes all pins are asynchronous to MCLK and that SCLK is slow enough
  (period >= ~4 MCLK cycles) for its edges to be sampled.
*/
// Behaviour
// - six bits: chan2..0, convert, standby, format
// - all control bits zero after reset
// - writes by parallel strobe or serial frame
// - short frame leaves register unchanged
// - short frame with convert set restarts conversion
// - first six falling clocks load; rest ignored
// - format one: twos complement, zero: binary
// - convert write fires timed settle pulse
// - channel bits select the multiplexer input
`timescale 1ns/1ps
module adcrw_ctrl import adcrw_pkg::*; #(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic MODE,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic [CTRL_W-1:0] DB,
  input wire logic SCLK,
  input wire logic WRITE_FRAME_SYNC_N,
  input wire logic DATA_IN,
  output logic [CHAN_W-1:0] CHANNEL_SEL,
  output logic SOFT_CONVERT_BIT,
  output logic STANDBY,
  output logic FORMAT_TWOS,
  output logic SETTLE_BUSY,
  output logic CONVERT_START
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [SY_W-1:0] sy;

  adcrw_sync #(
    .W(SY_W),
    .RST_VAL(SY_RST)
  ) u_sync (
    .clk(MCLK),
    .rst_n(RST_N),
    .d({DATA_IN, WRITE_FRAME_SYNC_N, SCLK, WR_N, CS_N, MODE, DB}),
    .q(sy)
  );

  logic par_mode;
  logic wr_s;
  logic cs_s;
  logic sclk_s;
  logic tfs_s;
  logic din_s;
  logic [CTRL_W-1:0] db_s;

  assign par_mode = sy[SY_MODE];
  assign wr_s = sy[SY_WR];
  assign cs_s = sy[SY_CS];
  assign sclk_s = sy[SY_SCLK];
  assign tfs_s = sy[SY_TFS];
  assign din_s = sy[SY_DIN];
  assign db_s = sy[SY_DB +: CTRL_W];

  // ----------------------------------------------------------------
  // state and next-state logic
  // ----------------------------------------------------------------
  adcrw_state_t s_r;
  adcrw_state_t s_nxt;
  logic par_evt;
  logic sclk_fall;
  logic tfs_fall;
  logic tfs_rise;
  logic ser_bit;
  logic short_end;
  logic wr_evt;
  logic start;
  logic [CTRL_W-1:0] wdata;

  // edge detection on synchronised pins
  always_comb begin
    par_evt = par_mode && !cs_s && wr_s && !s_r.wr_q;
    sclk_fall = !sclk_s && s_r.sclk_q;
    tfs_fall = !tfs_s && s_r.tfs_q;
    tfs_rise = tfs_s && !s_r.tfs_q;
    ser_bit = !par_mode && !tfs_s && !tfs_fall && sclk_fall && (s_r.bitcnt < SER_BITS);
    short_end = !par_mode && tfs_rise && (s_r.bitcnt < SER_BITS);
  end

  // register load, serial shift and settle timer
  always_comb begin
    s_nxt = s_r;
    s_nxt.conv_start = 1'b0;
    s_nxt.wr_q = wr_s;
    s_nxt.sclk_q = sclk_s;
    s_nxt.tfs_q = tfs_s;
    wr_evt = 1'b0;
    wdata = s_r.ctrl;
    if (par_evt) begin
      wr_evt = 1'b1;
      wdata = db_s;
    end
    if (!par_mode && tfs_fall) begin
      s_nxt.bitcnt = '0;
    end else if (ser_bit) begin
      s_nxt.shift = {s_r.shift[CTRL_W-2:0], din_s};
      s_nxt.bitcnt = s_r.bitcnt + 3'h1;
      if (s_r.bitcnt == SER_BITS - 3'h1) begin
        wr_evt = 1'b1;
        wdata = {s_r.shift[CTRL_W-2:0], din_s};
      end
    end
    if (wr_evt) begin
      s_nxt.ctrl = wdata;
    end
    // short frame keeps the register but may retrigger
    start = (wr_evt && wdata[CONV_POS]) || (short_end && s_r.ctrl[CONV_POS]);
    if (start) begin
      s_nxt.conv = ADCRW_SETTLE;
      s_nxt.cnt = CNT_W'(SETTLE_CYCLES - 1);
    end else begin
      case (s_r.conv)
        ADCRW_IDLE: begin
          s_nxt.cnt = '0;
        end
        ADCRW_SETTLE: begin
          if (s_r.cnt == '0) begin
            s_nxt.conv = ADCRW_IDLE;
            s_nxt.conv_start = 1'b1;
          end else begin
            s_nxt.cnt = s_r.cnt - 12'h001;
          end
        end
        default: begin
          s_nxt.conv = ADCRW_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from state flops
  assign CHANNEL_SEL = s_r.ctrl[CHAN_LSB +: CHAN_W];
  assign SOFT_CONVERT_BIT = s_r.ctrl[CONV_POS];
  assign STANDBY = s_r.ctrl[STBY_POS];
  assign FORMAT_TWOS = s_r.ctrl[FMT_POS];
  assign SETTLE_BUSY = s_r.conv;
  assign CONVERT_START = s_r.conv_start;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(RST_N) |-> (s_r.ctrl == CTRL_RST) && !CONVERT_START)
    else $error("control register not clear after reset");

  par_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    par_evt |=> (CHANNEL_SEL == $past(db_s[CHAN_LSB +: CHAN_W])))
    else $error("parallel write did not load channel bits");

  short_frame_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (short_end && !par_evt) |=> $stable(s_r.ctrl))
    else $error("short serial frame changed the register");

  short_conv_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (short_end && s_r.ctrl[CONV_POS]) |=> SETTLE_BUSY)
    else $error("short frame with convert set did not restart");

  sixth_bit_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (ser_bit && s_r.bitcnt == SER_BITS - 3'h1)
      |=> (s_r.ctrl == {$past(s_r.shift[CTRL_W-2:0]), $past(din_s)}))
    else $error("sixth serial bit did not load the register");

  late_bits_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!par_mode && !tfs_s && sclk_fall && s_r.bitcnt == SER_BITS && !par_evt)
      |=> $stable(s_r.ctrl))
    else $error("bit after the sixth altered the register");

  fmt_stby_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_evt |=> (FORMAT_TWOS == $past(wdata[FMT_POS])) && (STANDBY == $past(wdata[STBY_POS])))
    else $error("format or standby output not from last write");

  settle_len_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(SETTLE_BUSY) |-> ##SETTLE_CYCLES (CONVERT_START || SETTLE_BUSY))
    else $error("settle pulse length wrong");

  conv_cause_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CONVERT_START |-> $past(SETTLE_BUSY) && !SETTLE_BUSY)
    else $error("conversion started without a settle pulse");

  zero_conv_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_evt && !wdata[CONV_POS] && !SETTLE_BUSY && !short_end) |=> !SETTLE_BUSY)
    else $error("write with convert clear started the timer");

  conv_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (wr_evt && wdata[CONV_POS]) |=> SETTLE_BUSY && !CONVERT_START)
    else $error("convert write did not start the settle pulse");

  busy_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (SETTLE_BUSY && s_r.cnt != '0) |=> SETTLE_BUSY)
    else $error("settle pulse ended before its count ran out");

  mode_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (par_mode && !par_evt) |=> $stable(s_r.ctrl))
    else $error("register changed in parallel mode without a strobe");
endmodule : adcrw_ctrl

// [adcrw_host.sv]
/*
  Host model that drives the parallel write strobe and the serial write frame.
  Assumes a 100 MHz mclk; every pin changes at its falling edge.
*/
`timescale 1ns/1ps
module adcrw_host (
  input wire logic mclk,
  output logic mode,
  output logic cs_n,
  output logic wr_n,
  output logic [5:0] db,
  output logic sclk,
  output logic fs_n,
  output logic din
);
  // ----------------------------------------------------------------
  // idle levels and write cycles
  // ----------------------------------------------------------------
  // idle levels; serial clock parked high
  initial begin
    mode = 1'b1;
    cs_n = 1'b1;
    wr_n = 1'b1;
    db = 6'h00;
    sclk = 1'b1;
    fs_n = 1'b1;
    din = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // parallel strobe; data held past the rising edge
  task automatic par_write(input logic [5:0] v, input logic m, input logic cs);
    mode = m;
    cyc(4);
    db = v;
    cs_n = cs;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(2);
    cs_n = 1'b1;
    db = ~v; // released bus shows no stale value
    cyc(4);
  endtask : par_write
  // serial frame, msb first, extra bits inverted
  task automatic ser_write(input logic [5:0] v, input int nclk);
    logic [7:0] bits;
    bits = {v, ~v[5:4]};
    mode = 1'b0;
    cyc(4);
    fs_n = 1'b0;
    cyc(4);
    for (int i = 0; i < nclk; i++) begin
      din = bits[7-i];
      cyc(8);
      sclk = 1'b0;
      cyc(8);
      sclk = 1'b1;
    end
    cyc(4);
    fs_n = 1'b1;
    din = ~din;
    cyc(1);
  endtask : ser_write
endmodule : adcrw_host

// [adcrw_ctrl_bench.sv]
/*
  Self-checking bench for the acquisition control register.
  Assumes a short settle count of 4 cycles on the design.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module adcrw_ctrl_bench import adcrw_pkg::*;;
  localparam int SETTLE = 4;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic mode, cs_n, wr_n, sclk, fs_n, din;
  logic [5:0] db;
  logic [2:0] chan;
  logic conv_bit, stby, fmt, busy, cstart;
  int mismatches = 0;
  int n_checks = 0;
  // ----------------------------------------------------------------
  // clock, host and design
  // ----------------------------------------------------------------
  initial forever #5 mclk = ~mclk;
  adcrw_host host (.mclk(mclk), .mode(mode), .cs_n(cs_n), .wr_n(wr_n), .db(db),
    .sclk(sclk), .fs_n(fs_n), .din(din));
  adcrw_ctrl #(.SETTLE_CYCLES(SETTLE)) uut (.MCLK(mclk), .RST_N(rst_n), .MODE(mode),
    .CS_N(cs_n), .WR_N(wr_n), .DB(db), .SCLK(sclk), .WRITE_FRAME_SYNC_N(fs_n),
    .DATA_IN(din), .CHANNEL_SEL(chan), .SOFT_CONVERT_BIT(conv_bit), .STANDBY(stby),
    .FORMAT_TWOS(fmt), .SETTLE_BUSY(busy), .CONVERT_START(cstart));
  // ----------------------------------------------------------------
  // shared checks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // settle, then compare all register fields
  task automatic check_regs(input logic [5:0] ex);
    host.cyc(6);
    `CHK("channel", ex[5:3], chan)
    `CHK("convert", ex[2], conv_bit)
    `CHK("standby", ex[1], stby)
    `CHK("format", ex[0], fmt)
  endtask : check_regs
  // time the settle pulse up to the convert start
  task automatic wait_conv;
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 200) begin
      host.cyc(1);
      n++;
    end
    if (busy !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    n = 0;
    while (cstart !== 1'b1 && n < 100) begin
      host.cyc(1);
      n++;
    end
    if (cstart !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    `CHK("settle cycles", SETTLE, n)
    `CHK("busy at start", 1'b0, busy)
  endtask : wait_conv
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check_regs(6'h00);
    `CHK("busy", 1'b0, busy)
  endtask : t_reset
  // every channel through the parallel port
  task automatic t_parallel;
    logic [5:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[2:0], 1'b0, i[0], i[1]};
      host.par_write(v, 1'b1, 1'b0);
      check_regs(v);
    end
  endtask : t_parallel
  // strobes in serial mode or unselected are ignored
  task automatic t_refused;
    host.par_write(6'h12, 1'b1, 1'b0);
    host.par_write(6'h2d, 1'b0, 1'b0);
    check_regs(6'h12);
    host.par_write(6'h2d, 1'b1, 1'b1);
    check_regs(6'h12);
  endtask : t_refused
  // long frame loads six bits, short frame loads none
  task automatic t_serial;
    host.ser_write(6'h2a, 8);
    check_regs(6'h2a);
    host.ser_write(6'h15, 3);
    check_regs(6'h2a);
    `CHK("busy short", 1'b0, busy)
  endtask : t_serial
  // convert writes on both ports; timer watched while the write runs
  task automatic t_convert;
    fork
      host.par_write(6'h0c, 1'b1, 1'b0);
      wait_conv();
    join
    host.ser_write(6'h00, 0);
    wait_conv();
    check_regs(6'h0c);
    fork
      host.ser_write(6'h1c, 6);
      wait_conv();
    join
    check_regs(6'h1c);
  endtask : t_convert
  // main sequence
  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    host.cyc(2);
    t_reset();
    t_parallel();
    t_refused();
    t_serial();
    t_convert();
    complete_run();
  end
endmodule : adcrw_ctrl_bench
